// *** drvdi_consts.svh ***
// Register offsets, field positions, reset values and timing counts for the drive input block.
`ifndef DRVDI_CONSTS_SVH
`define DRVDI_CONSTS_SVH

`define DRVDI_ADDR_W 6
`define DRVDI_OFF_FUNC_BASE 6'h00
`define DRVDI_OFF_CONFIG 6'h20
`define DRVDI_OFF_BRAKE 6'h24
`define DRVDI_OFF_RAMP 6'h28
`define DRVDI_OFF_CMD 6'h2C
`define DRVDI_OFF_STATUS 6'h30
`define DRVDI_OFF_REF_HOLD 6'h34
`define DRVDI_OFF_FREQ_HOLD 6'h38

`define DRVDI_CFG_CLOSED_BIT 0
`define DRVDI_CFG_SETUP_LSB 1
`define DRVDI_CFG_SETUP_W 3
`define DRVDI_CFG_REFTYPE_LSB 4
`define DRVDI_CFG_REFTYPE_W 2
`define DRVDI_BRAKE_CUR_LSB 0
`define DRVDI_BRAKE_TIME_LSB 16
`define DRVDI_RAMP_UP_LSB 0
`define DRVDI_RAMP_DN_LSB 16
`define DRVDI_CMD_KEY_STOP_BIT 0

`define DRVDI_FUNC_RST 5'h00
`define DRVDI_CONFIG_RST 6'h00
`define DRVDI_BRAKE_RST 16'h0000
`define DRVDI_RAMP_RST 16'h03E8
`define DRVDI_HOLD_RST 16'h0000

`define DRVDI_SETUP_MULTI 3'h5
`define DRVDI_REF_REMOTE_PRESET 2'h2
`define DRVDI_DCB_PIN_MASK 8'h18

`define DRVDI_CLK_KHZ 10000
`define DRVDI_PULSE_MIN_US 3000
`define DRVDI_PULSE_MIN_CYC ((`DRVDI_PULSE_MIN_US * `DRVDI_CLK_KHZ + 999) / 1000)

`endif

// *** drvdi_pkg.sv ***
// Types shared by the drive input block: input function codes and bus states.
`default_nettype none
package drvdi_pkg;

	typedef enum logic [4:0] {
		DRVDI_FN_NONE = 5'h00,
		DRVDI_FN_RESET = 5'h01,
		DRVDI_FN_COAST_N = 5'h02,
		DRVDI_FN_FREEWHEEL_CLEAR_N = 5'h03,
		DRVDI_FN_START = 5'h04,
		DRVDI_FN_REVERSE = 5'h05,
		DRVDI_FN_REVERSE_START = 5'h06,
		DRVDI_FN_DC_HOLD_BRAKE_N = 5'h07,
		DRVDI_FN_INTERLOCK = 5'h08,
		DRVDI_FN_FREEZE_REF = 5'h09,
		DRVDI_FN_FREEZE_OUT = 5'h0A,
		DRVDI_FN_SETUP_LSB = 5'h0B,
		DRVDI_FN_SETUP_MSB = 5'h0C,
		DRVDI_FN_PRESET_ON = 5'h0D,
		DRVDI_FN_PRESET_LSB = 5'h0E,
		DRVDI_FN_PRESET_MSB = 5'h0F,
		DRVDI_FN_SPEED_DOWN = 5'h10,
		DRVDI_FN_SPEED_UP = 5'h11,
		DRVDI_FN_LATCHED_START = 5'h12,
		DRVDI_FN_STOP_N = 5'h13
	} drvdi_fn_e;

	typedef enum logic {
		DRVDI_BUS_IDLE = 1'b0,
		DRVDI_BUS_ACK = 1'b1
	} drvdi_bus_e;

endpackage
`default_nettype wire

// *** drvdi_input_cond.sv ***
// Per-input synchroniser, edge detector and minimum-high-time qualifier.
`default_nettype none
module drvdi_input_cond #(
	parameter int NUM_IN = 8,
	parameter int CNT_W = 16,
	parameter logic [CNT_W-1:0] PULSE_MIN = 16'h7530
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [NUM_IN-1:0] pins,
	output logic [NUM_IN-1:0] level,
	output logic [NUM_IN-1:0] rise,
	output logic [NUM_IN-1:0] fall,
	output logic [NUM_IN-1:0] qual
);

	genvar g;
	generate
		for (g = 0; g < NUM_IN; g++)
		begin : g_in
			logic meta_r;
			logic sync_r;
			logic lvl_r;
			logic rise_r;
			logic fall_r;
			logic qual_r;
			logic qual_nxt;
			logic [CNT_W-1:0] cnt_r;
			logic [CNT_W-1:0] cnt_nxt;

			// The high time is counted on the synchronised level, and qual pulses once on reaching it.
			always_comb
			begin
				cnt_nxt = cnt_r;
				qual_nxt = 1'b0;
				if (!sync_r)
					cnt_nxt = '0;
				else if (cnt_r < PULSE_MIN)
				begin
					cnt_nxt = cnt_r + 1'b1;
					qual_nxt = (cnt_r == PULSE_MIN - 1'b1);
				end
			end

			always_ff @(posedge core_clk or posedge reset)
			begin
				if (reset)
				begin
					meta_r <= 1'b0;
					sync_r <= 1'b0;
					lvl_r <= 1'b0;
					rise_r <= 1'b0;
					fall_r <= 1'b0;
					qual_r <= 1'b0;
					cnt_r <= '0;
				end
				else
				begin
					meta_r <= pins[g];
					sync_r <= meta_r;
					lvl_r <= sync_r;
					rise_r <= sync_r & ~lvl_r;
					fall_r <= ~sync_r & lvl_r;
					qual_r <= qual_nxt;
					cnt_r <= cnt_nxt;
				end
			end

			assign level[g] = lvl_r;
			assign rise[g] = rise_r;
			assign fall[g] = fall_r;
			assign qual[g] = qual_r;
		end
	endgenerate

endmodule
`default_nettype wire

// *** drvdi_top.sv ***
// Digital input function logic of a motor drive with an Avalon-MM register slave.
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`include "drvdi_consts.svh"
`default_nettype none

// What this block does
// - Reset input clears resettable alarms on rise
// - Inverted coast low disables the power stage
// - Coast-and-reset coasts low, resets on fall
// - DC brake low brakes if current, time nonzero; only pins set in DCB_PIN_MASK
// - Interlock coasts and raises clearable external fault
// - Run input high runs, low stops
// - Direction reverses when high, ignored closed loop
// - Reverse-and-run starts reversed, not closed loop
// - Frozen reference held, changed only by speed inputs
// - Frozen output frequency changed only by speed inputs
// - Output freeze: only DC brake input stops
// - Multi-setup code selects setup from bit pair
// - Preset enable chooses preset over remote references
// - Preset bit pair selects one of four presets
// - Speed inputs act only while something frozen
// - Held speed inputs ramp at configured rates
// - Qualified speed pulse steps one unit, saturating; up and down in one cycle cancel
// - No-function inputs are ignored entirely
// - Latched run starts on 3 ms pulse without stop
module drvdi_top
	import drvdi_pkg::*;
#(
	parameter int NUM_IN = 8,
	parameter int PULSE_MIN_CYC = `DRVDI_PULSE_MIN_CYC,
	parameter logic [7:0] DCB_PIN_MASK = `DRVDI_DCB_PIN_MASK
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [NUM_IN-1:0] din,
	input wire logic [`DRVDI_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [15:0] ref_in,
	input wire logic [15:0] freq_in,
	input wire logic alarm_trip,
	input wire logic alarm_lock_trip,
	output logic run_request,
	output logic reverse_dir,
	output logic output_disable,
	output logic dc_brake_on,
	output logic alarm_reset_pulse,
	output logic alarm_active,
	output logic ext_fault_alarm,
	output logic setup_multi,
	output logic [1:0] setup_index,
	output logic preset_enable,
	output logic [1:0] preset_index,
	output logic ref_hold_valid,
	output logic [15:0] ref_hold_value,
	output logic freq_hold_valid,
	output logic [15:0] freq_hold_value
);

	localparam logic [15:0] PULSE_MIN = PULSE_MIN_CYC[15:0];
	logic [NUM_IN-1:0] lvl, rise, fall, qual;
	drvdi_input_cond #(.NUM_IN(NUM_IN), .CNT_W(16), .PULSE_MIN(PULSE_MIN)) i_drvdi_input_cond (
		.core_clk(core_clk),
		.reset(reset),
		.pins(din),
		.level(lvl),
		.rise(rise),
		.fall(fall),
		.qual(qual)
	);

	logic [4:0] func_r [NUM_IN], func_nxt [NUM_IN];
	logic [5:0] config_r, config_nxt;
	logic [15:0] brake_cur_r, brake_cur_nxt, brake_time_r, brake_time_nxt;
	logic [15:0] ramp_r [2], ramp_nxt [2];
	drvdi_bus_e bus_r, bus_nxt;
	logic wait_r, wait_nxt, key_stop;
	logic [31:0] rdata_r, rdata_nxt, rd_mux;
	logic [31:0] fn_hi, fn_lo, fn_rise, fn_fall, fn_qual;
	logic closed_loop, dcb_active, reset_evt, frz_any, run_cmd;
	logic run_r, run_nxt, rev_r, rev_nxt, odis_r, odis_nxt, dcb_r, arst_r;
	logic alarm_r, alarm_nxt, locked_r, locked_nxt, ext_r, ext_nxt, alarm_any_r;
	logic latch_r, latch_nxt, smulti_r, smulti_nxt, pen_r, pen_nxt, refv_r, freqv_r;
	logic [1:0] sidx_r, sidx_nxt, pidx_r, pidx_nxt, step, arm_r, arm_nxt;
	logic [15:0] refval_r, refval_nxt, freqval_r, freqval_nxt;
	logic [15:0] rcnt_r [2], rcnt_nxt [2];

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] mask;
		mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (wd & mask) | (old & ~mask);
	endfunction

	function automatic logic [15:0] hold_step(input logic [15:0] v, input logic [1:0] s);
		if (s == 2'b01 && v != 16'hFFFF)
			return v + 16'h0001;
		if (s == 2'b10 && v != 16'h0000)
			return v - 16'h0001;
		return v;
	endfunction

	// Gather the sampled inputs per assigned function; code zero is collected but never used.
	always_comb
	begin
		fn_hi = '0;
		fn_lo = '0;
		fn_rise = '0;
		fn_fall = '0;
		fn_qual = '0;
		for (int i = 0; i < NUM_IN; i++)
		begin
			if (func_r[i] != DRVDI_FN_DC_HOLD_BRAKE_N || DCB_PIN_MASK[i])
			begin
				fn_hi[func_r[i]] = fn_hi[func_r[i]] | lvl[i];
				fn_lo[func_r[i]] = fn_lo[func_r[i]] | ~lvl[i];
				fn_rise[func_r[i]] = fn_rise[func_r[i]] | rise[i];
				fn_fall[func_r[i]] = fn_fall[func_r[i]] | fall[i];
				fn_qual[func_r[i]] = fn_qual[func_r[i]] | qual[i];
			end
		end
	end

	always_comb
	begin
		closed_loop = config_r[`DRVDI_CFG_CLOSED_BIT];
		dcb_active = fn_lo[DRVDI_FN_DC_HOLD_BRAKE_N] && brake_cur_r != 16'h0000
			&& brake_time_r != 16'h0000;
		reset_evt = fn_rise[DRVDI_FN_RESET] | fn_fall[DRVDI_FN_FREEWHEEL_CLEAR_N];
		frz_any = refv_r | freqv_r;
		latch_nxt = latch_r;
		if (fn_lo[DRVDI_FN_STOP_N])
			latch_nxt = 1'b0;
		else if (fn_qual[DRVDI_FN_LATCHED_START])
			latch_nxt = 1'b1;
		run_cmd = fn_hi[DRVDI_FN_START] | latch_r
			| (fn_hi[DRVDI_FN_REVERSE_START] & ~closed_loop);
		if (freqv_r)
			run_nxt = (run_r | run_cmd) & ~dcb_active;
		else
			run_nxt = run_cmd;
		rev_nxt = ~closed_loop
			& (fn_hi[DRVDI_FN_REVERSE] | fn_hi[DRVDI_FN_REVERSE_START]);
		odis_nxt = fn_lo[DRVDI_FN_COAST_N] | fn_lo[DRVDI_FN_FREEWHEEL_CLEAR_N]
			| fn_lo[DRVDI_FN_INTERLOCK];
		alarm_nxt = alarm_trip | (alarm_r & ~reset_evt);
		locked_nxt = alarm_lock_trip | locked_r;
		ext_nxt = fn_lo[DRVDI_FN_INTERLOCK] | (ext_r & ~(reset_evt | key_stop));
		smulti_nxt = config_r[`DRVDI_CFG_SETUP_LSB +: `DRVDI_CFG_SETUP_W] == `DRVDI_SETUP_MULTI;
		sidx_nxt = smulti_nxt ? {fn_hi[DRVDI_FN_SETUP_MSB], fn_hi[DRVDI_FN_SETUP_LSB]}
			: 2'h0;
		pen_nxt = config_r[`DRVDI_CFG_REFTYPE_LSB +: `DRVDI_CFG_REFTYPE_W]
			== `DRVDI_REF_REMOTE_PRESET && fn_hi[DRVDI_FN_PRESET_ON];
		pidx_nxt = {fn_hi[DRVDI_FN_PRESET_MSB], fn_hi[DRVDI_FN_PRESET_LSB]};
	end

	// Speed steps: one on a qualified pulse, then one per ramp period while held.
	always_comb
	begin
		logic held, q;
		held = 1'b0;
		q = 1'b0;
		for (int d = 0; d < 2; d++)
		begin
			held = (d == 0) ? fn_hi[DRVDI_FN_SPEED_UP] : fn_hi[DRVDI_FN_SPEED_DOWN];
			q = (d == 0) ? fn_qual[DRVDI_FN_SPEED_UP] : fn_qual[DRVDI_FN_SPEED_DOWN];
			step[d] = 1'b0;
			arm_nxt[d] = arm_r[d];
			rcnt_nxt[d] = rcnt_r[d];
			if (!held || !frz_any)
			begin
				arm_nxt[d] = 1'b0;
				rcnt_nxt[d] = '0;
			end
			else if (q)
			begin
				step[d] = 1'b1;
				arm_nxt[d] = 1'b1;
				rcnt_nxt[d] = '0;
			end
			else if (arm_r[d] && ramp_r[d] != 16'h0000)
			begin
				if (rcnt_r[d] >= ramp_r[d] - 16'h0001)
				begin
					step[d] = 1'b1;
					rcnt_nxt[d] = '0;
				end
				else
					rcnt_nxt[d] = rcnt_r[d] + 16'h0001;
			end
		end
	end

	// Held values survive stops; they are captured on freezing and move only by steps.
	always_comb
	begin
		refval_nxt = refval_r;
		freqval_nxt = freqval_r;
		if (fn_hi[DRVDI_FN_FREEZE_REF] && !refv_r)
			refval_nxt = ref_in;
		else if (refv_r)
			refval_nxt = hold_step(refval_r, step);
		if (fn_hi[DRVDI_FN_FREEZE_OUT] && !freqv_r)
			freqval_nxt = freq_in;
		else if (freqv_r)
			freqval_nxt = hold_step(freqval_r, step);
	end

	always_comb
	begin
		if (avs_address[5] == 1'b0)
			rd_mux = {27'h0, func_r[avs_address[4:2]]};
		else
		begin
			unique case (avs_address)
				`DRVDI_OFF_CONFIG: rd_mux = {26'h0, config_r};
				`DRVDI_OFF_BRAKE: rd_mux = {brake_time_r, brake_cur_r};
				`DRVDI_OFF_RAMP: rd_mux = {ramp_r[1], ramp_r[0]};
				`DRVDI_OFF_STATUS: rd_mux = {8'h0, 8'(lvl), latch_r, freqv_r, refv_r, pidx_r,
					pen_r, sidx_r, smulti_r, ext_r, locked_r, alarm_r, dcb_r, odis_r, rev_r,
					run_r};
				`DRVDI_OFF_REF_HOLD: rd_mux = {16'h0, refval_r};
				`DRVDI_OFF_FREQ_HOLD: rd_mux = {16'h0, freqval_r};
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	// Request is accepted in IDLE and answered by a single low waitrequest cycle.
	always_comb
	begin
		logic [31:0] m;
		m = be_merge(32'h0, avs_writedata, avs_byteenable);
		bus_nxt = bus_r;
		wait_nxt = 1'b1;
		rdata_nxt = rdata_r;
		key_stop = 1'b0;
		func_nxt = func_r;
		config_nxt = config_r;
		brake_cur_nxt = brake_cur_r;
		brake_time_nxt = brake_time_r;
		ramp_nxt = ramp_r;
		unique case (bus_r)
			DRVDI_BUS_IDLE:
			begin
				if (avs_read || avs_write)
				begin
					bus_nxt = DRVDI_BUS_ACK;
					wait_nxt = 1'b0;
					rdata_nxt = avs_read ? rd_mux : rdata_r;
				end
			end
			DRVDI_BUS_ACK:
			begin
				bus_nxt = DRVDI_BUS_IDLE;
				if (avs_write)
				begin
					m = be_merge(rd_mux, avs_writedata, avs_byteenable);
					if (avs_address[5] == 1'b0)
						func_nxt[avs_address[4:2]] = m[4:0];
					else if (avs_address == `DRVDI_OFF_CONFIG)
						config_nxt = m[5:0];
					else if (avs_address == `DRVDI_OFF_BRAKE)
					begin
						brake_cur_nxt = m[`DRVDI_BRAKE_CUR_LSB +: 16];
						brake_time_nxt = m[`DRVDI_BRAKE_TIME_LSB +: 16];
					end
					else if (avs_address == `DRVDI_OFF_RAMP)
					begin
						ramp_nxt[0] = m[`DRVDI_RAMP_UP_LSB +: 16];
						ramp_nxt[1] = m[`DRVDI_RAMP_DN_LSB +: 16];
					end
					else if (avs_address == `DRVDI_OFF_CMD)
						key_stop = avs_byteenable[0] && avs_writedata[`DRVDI_CMD_KEY_STOP_BIT];
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			func_r <= '{default: `DRVDI_FUNC_RST};
			config_r <= `DRVDI_CONFIG_RST;
			brake_cur_r <= `DRVDI_BRAKE_RST;
			brake_time_r <= `DRVDI_BRAKE_RST;
			ramp_r <= '{default: `DRVDI_RAMP_RST};
			bus_r <= DRVDI_BUS_IDLE;
			wait_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
			run_r <= 1'b0;
			rev_r <= 1'b0;
			odis_r <= 1'b0;
			dcb_r <= 1'b0;
			arst_r <= 1'b0;
			alarm_r <= 1'b0;
			alarm_any_r <= 1'b0;
			locked_r <= 1'b0;
			ext_r <= 1'b0;
			latch_r <= 1'b0;
			smulti_r <= 1'b0;
			sidx_r <= 2'h0;
			pen_r <= 1'b0;
			pidx_r <= 2'h0;
			refv_r <= 1'b0;
			freqv_r <= 1'b0;
			refval_r <= `DRVDI_HOLD_RST;
			freqval_r <= `DRVDI_HOLD_RST;
			arm_r <= 2'h0;
			rcnt_r <= '{default: 16'h0000};
		end
		else
		begin
			func_r <= func_nxt;
			config_r <= config_nxt;
			brake_cur_r <= brake_cur_nxt;
			brake_time_r <= brake_time_nxt;
			ramp_r <= ramp_nxt;
			bus_r <= bus_nxt;
			wait_r <= wait_nxt;
			rdata_r <= rdata_nxt;
			run_r <= run_nxt;
			rev_r <= rev_nxt;
			odis_r <= odis_nxt;
			dcb_r <= dcb_active;
			arst_r <= reset_evt;
			alarm_r <= alarm_nxt;
			alarm_any_r <= alarm_nxt | locked_nxt;
			locked_r <= locked_nxt;
			ext_r <= ext_nxt;
			latch_r <= latch_nxt;
			smulti_r <= smulti_nxt;
			sidx_r <= sidx_nxt;
			pen_r <= pen_nxt;
			pidx_r <= pidx_nxt;
			refv_r <= fn_hi[DRVDI_FN_FREEZE_REF];
			freqv_r <= fn_hi[DRVDI_FN_FREEZE_OUT];
			refval_r <= refval_nxt;
			freqval_r <= freqval_nxt;
			arm_r <= arm_nxt;
			rcnt_r <= rcnt_nxt;
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign run_request = run_r;
	assign reverse_dir = rev_r;
	assign output_disable = odis_r;
	assign dc_brake_on = dcb_r;
	assign alarm_reset_pulse = arst_r;
	assign alarm_active = alarm_any_r;
	assign ext_fault_alarm = ext_r;
	assign setup_multi = smulti_r;
	assign setup_index = sidx_r;
	assign preset_enable = pen_r;
	assign preset_index = pidx_r;
	assign ref_hold_valid = refv_r;
	assign ref_hold_value = refval_r;
	assign freq_hold_valid = freqv_r;
	assign freq_hold_value = freqval_r;

endmodule
`default_nettype wire

// *** drvdi_checker.sv ***
// Port-level checker of the drive input block: bus handshake, alarms and frozen stop.
`default_nettype none
module drvdi_checker #(
	parameter int NUM_IN = 8
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [NUM_IN-1:0] din,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic alarm_trip,
	input wire logic alarm_lock_trip,
	input wire logic alarm_active,
	input wire logic alarm_reset_pulse,
	input wire logic run_request,
	input wire logic output_disable,
	input wire logic dc_brake_on,
	input wire logic ext_fault_alarm,
	input wire logic preset_enable,
	input wire logic freq_hold_valid
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	property p_ack;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer late");
	property p_ack_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("bus answer too long");
	property p_no_req;
		!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_no_req: assert property (p_no_req) else $error("answer without request");
	property p_unmap;
		avs_read && avs_waitrequest && avs_address == 6'h3C |=> avs_readdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_lock;
		alarm_lock_trip |=> alarm_active [*8];
	endproperty
	a_lock: assert property (p_lock) else $error("locked alarm cleared");
	property p_trip;
		alarm_trip |=> alarm_active;
	endproperty
	a_trip: assert property (p_trip) else $error("alarm not raised");
	property p_pulse;
		alarm_reset_pulse |=> !alarm_reset_pulse;
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset pulse too long");
	property p_ilk;
		$rose(ext_fault_alarm) |-> output_disable;
	endproperty
	a_ilk: assert property (p_ilk) else $error("fault without coast");
	property p_frz;
		$fell(run_request) && $past(freq_hold_valid) |-> dc_brake_on || $past(dc_brake_on);
	endproperty
	a_frz: assert property (p_frz) else $error("frozen run stopped");
	c_read: cover property (avs_read && !avs_waitrequest);
	c_brake: cover property (dc_brake_on);
	c_frz: cover property (freq_hold_valid && run_request);
	c_preset: cover property (din[NUM_IN-1] && preset_enable);
endmodule
bind drvdi_top drvdi_checker #(.NUM_IN(NUM_IN)) i_drvdi_checker (.core_clk(core_clk),
	.reset(reset), .din(din), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.alarm_trip(alarm_trip), .alarm_lock_trip(alarm_lock_trip), .alarm_active(alarm_active),
	.alarm_reset_pulse(alarm_reset_pulse), .run_request(run_request),
	.output_disable(output_disable), .dc_brake_on(dc_brake_on),
	.ext_fault_alarm(ext_fault_alarm), .preset_enable(preset_enable),
	.freq_hold_valid(freq_hold_valid));
`default_nettype wire

// *** drvdi_sw_model.sv ***
// Switch-panel model that drives the digital input levels of the drive.
`default_nettype none
module drvdi_sw_model (
	input wire logic core_clk,
	output logic [7:0] din
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] lvl_r = 8'h00;
	assign din = lvl_r;
	task automatic pin(input int i, input logic v);
		@(posedge core_clk);
		lvl_r[i] <= v;
	endtask
	// A pulse stays high, then low, for n cycles each, never shorter.
	task automatic pulse(input int i, input int n);
		@(posedge core_clk);
		lvl_r[i] <= 1'b1;
		repeat (n) @(posedge core_clk);
		lvl_r[i] <= 1'b0;
		repeat (n) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// *** tb_drvdi_top.sv ***
// Self-checking bench of the drive input block.
`default_nettype none
module tb_drvdi_top
	import drvdi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int P = 20;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] din;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rq;
	logic avs_waitrequest, alarm_trip = 1'b0, alarm_lock_trip = 1'b0;
	logic [15:0] ref_in = 16'h0064, freq_in = 16'h0123, ref_hold_value, freq_hold_value;
	logic run_request, reverse_dir, output_disable, dc_brake_on, alarm_reset_pulse;
	logic alarm_active, ext_fault_alarm, setup_multi, preset_enable;
	logic ref_hold_valid, freq_hold_valid;
	logic [1:0] setup_index, preset_index;
	int bad_count = 0;
	int tests_run = 0;
	initial forever #50 core_clk = !core_clk;
	drvdi_top #(.PULSE_MIN_CYC(P)) i_drvdi_top (.core_clk(core_clk), .reset(reset),
		.din(din), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .ref_in(ref_in), .freq_in(freq_in),
		.alarm_trip(alarm_trip), .alarm_lock_trip(alarm_lock_trip),
		.run_request(run_request), .reverse_dir(reverse_dir),
		.output_disable(output_disable), .dc_brake_on(dc_brake_on),
		.alarm_reset_pulse(alarm_reset_pulse), .alarm_active(alarm_active),
		.ext_fault_alarm(ext_fault_alarm), .setup_multi(setup_multi),
		.setup_index(setup_index), .preset_enable(preset_enable),
		.preset_index(preset_index), .ref_hold_valid(ref_hold_valid),
		.ref_hold_value(ref_hold_value), .freq_hold_valid(freq_hold_valid),
		.freq_hold_value(freq_hold_value));
	drvdi_sw_model i_drvdi_sw_model (.core_clk(core_clk), .din(din));
	task automatic results();
		if (bad_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		rq = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50)
		begin
			bad_count++;
			$display("mismatch at %0t: bus timeout", $time);
			results();
		end
	endtask
	task automatic f(input int i, input logic [4:0] c);
		bus(1'b1, 6'(4 * i), {27'h0, c});
	endtask
	task automatic pn(input int i, input logic v);
		i_drvdi_sw_model.pin(i, v);
	endtask
	task automatic st();
		repeat (6) @(posedge core_clk);
	endtask
	task automatic rst();
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
	endtask
	task automatic clr();
		for (int i = 0; i < 8; i++)
			pn(i, 1'b0);
		for (int i = 0; i < 8; i++)
			f(i, DRVDI_FN_NONE);
		st();
	endtask
	task automatic trip(input logic lk);
		@(posedge core_clk);
		alarm_trip <= !lk;
		alarm_lock_trip <= lk;
		@(posedge core_clk);
		alarm_trip <= 1'b0;
		alarm_lock_trip <= 1'b0;
		st();
	endtask
	task automatic t_regs();
		chk(avs_waitrequest, 1'b1);
		bus(1'b0, 6'h28, 32'h0);
		chk(rq, 32'h03E803E8);
		bus(1'b1, 6'h3C, 32'hFFFFFFFF);
		bus(1'b0, 6'h3C, 32'h0);
		chk(rq, 32'h0);
		pn(2, 1'b0);
		st();
		chk(output_disable, 1'b0);
	endtask
	task automatic t_stops();
		pn(2, 1'b1);
		pn(3, 1'b1);
		pn(4, 1'b1);
		f(2, DRVDI_FN_COAST_N);
		f(3, DRVDI_FN_DC_HOLD_BRAKE_N);
		f(4, DRVDI_FN_INTERLOCK);
		pn(2, 1'b0);
		st();
		chk(output_disable, 1'b1);
		pn(2, 1'b1);
		pn(3, 1'b0);
		bus(1'b1, 6'h24, 32'h00000005);
		st();
		chk({output_disable, dc_brake_on}, 2'b00);
		bus(1'b1, 6'h24, 32'h00050005);
		st();
		chk(dc_brake_on, 1'b1);
		pn(3, 1'b1);
		pn(4, 1'b0);
		st();
		chk({dc_brake_on, ext_fault_alarm, output_disable}, 3'b011);
		pn(4, 1'b1);
		st();
		chk({ext_fault_alarm, output_disable}, 2'b10);
		bus(1'b1, 6'h2C, 32'h1);
		st();
		chk(ext_fault_alarm, 1'b0);
		clr();
	endtask
	task automatic t_run();
		f(5, DRVDI_FN_START);
		f(6, DRVDI_FN_REVERSE);
		pn(6, 1'b1);
		st();
		chk({run_request, reverse_dir}, 2'b01);
		pn(5, 1'b1);
		st();
		chk({run_request, reverse_dir}, 2'b11);
		bus(1'b1, 6'h20, 32'h1);
		pn(5, 1'b0);
		st();
		chk({run_request, reverse_dir}, 2'b00);
		f(5, DRVDI_FN_NONE);
		f(6, DRVDI_FN_REVERSE_START);
		st();
		chk(run_request, 1'b0);
		bus(1'b1, 6'h20, 32'h0);
		st();
		chk({run_request, reverse_dir}, 2'b11);
		clr();
	endtask
	task automatic t_select();
		f(0, DRVDI_FN_SETUP_LSB);
		f(1, DRVDI_FN_SETUP_MSB);
		f(2, DRVDI_FN_PRESET_LSB);
		f(3, DRVDI_FN_PRESET_MSB);
		f(7, DRVDI_FN_PRESET_ON);
		bus(1'b1, 6'h20, 32'h0000002A);
		for (int k = 0; k < 4; k++)
		begin
			pn(0, k[0]);
			pn(1, k[1]);
			pn(2, k[0]);
			pn(3, k[1]);
			pn(7, k[0]);
			st();
			chk({setup_multi, setup_index}, {1'b1, 2'(k)});
			chk({preset_enable, preset_index}, {k[0], 2'(k)});
		end
		bus(1'b1, 6'h20, 32'h0);
		clr();
	endtask
	task automatic t_freeze();
		f(0, DRVDI_FN_FREEZE_REF);
		f(1, DRVDI_FN_SPEED_UP);
		f(2, DRVDI_FN_SPEED_DOWN);
		bus(1'b1, 6'h28, 32'h0);
		i_drvdi_sw_model.pulse(1, P + 3);
		chk({ref_hold_valid, ref_hold_value}, 17'h00000);
		pn(0, 1'b1);
		st();
		ref_in <= 16'h0200;
		i_drvdi_sw_model.pulse(1, P + 3);
		i_drvdi_sw_model.pulse(1, P + 3);
		i_drvdi_sw_model.pulse(2, P + 3);
		chk({ref_hold_valid, ref_hold_value}, 17'h10065);
		bus(1'b1, 6'h28, 32'h000A000A);
		pn(1, 1'b1);
		repeat (P + 100) @(posedge core_clk);
		pn(1, 1'b0);
		repeat (P + 6) @(posedge core_clk);
		chk(ref_hold_value >= 16'h006D && ref_hold_value <= 16'h0072, 1'b1);
		rq = {16'h0, ref_hold_value};
		pn(0, 1'b0);
		st();
		chk({ref_hold_valid, ref_hold_value}, {1'b0, rq[15:0]});
		clr();
	endtask
	task automatic t_hold_out();
		f(0, DRVDI_FN_FREEZE_OUT);
		f(1, DRVDI_FN_SPEED_UP);
		f(5, DRVDI_FN_START);
		pn(3, 1'b1);
		f(3, DRVDI_FN_DC_HOLD_BRAKE_N);
		pn(5, 1'b1);
		pn(0, 1'b1);
		st();
		i_drvdi_sw_model.pulse(1, P + 3);
		chk({freq_hold_valid, freq_hold_value}, 17'h10124);
		pn(5, 1'b0);
		st();
		chk(run_request, 1'b1);
		pn(3, 1'b0);
		st();
		chk(run_request, 1'b0);
		clr();
	endtask
	task automatic t_latch();
		pn(1, 1'b1);
		f(0, DRVDI_FN_LATCHED_START);
		f(1, DRVDI_FN_STOP_N);
		i_drvdi_sw_model.pulse(0, P - 5);
		chk(run_request, 1'b0);
		i_drvdi_sw_model.pulse(0, P + 3);
		chk(run_request, 1'b1);
		pn(1, 1'b0);
		pn(1, 1'b1);
		st();
		chk(run_request, 1'b0);
		clr();
	endtask
	task automatic t_alarm();
		pn(1, 1'b1);
		f(0, DRVDI_FN_RESET);
		f(1, DRVDI_FN_FREEWHEEL_CLEAR_N);
		trip(1'b0);
		chk(alarm_active, 1'b1);
		i_drvdi_sw_model.pulse(0, 4);
		st();
		chk(alarm_active, 1'b0);
		trip(1'b0);
		pn(1, 1'b0);
		st();
		chk({alarm_active, output_disable}, 2'b01);
		trip(1'b1);
		i_drvdi_sw_model.pulse(0, 4);
		st();
		chk(alarm_active, 1'b1);
		rst();
		st();
		chk({alarm_active, output_disable}, 2'b00);
	endtask
	initial
	begin
		rst();
		t_regs();
		t_stops();
		t_run();
		t_select();
		t_freeze();
		t_hold_out();
		t_latch();
		t_alarm();
		results();
	end
endmodule
`default_nettype wire
